// >>> rtl/idt_top.sv
`timescale 1ns/1ns
// Contract
// - Sixteen input channels 0..15 have levels the host can read.
// - Sixteen output channels 0..15 take and hold the levels the host writes.
// - Power-up, hardware reset and software reset drive every output channel low.
// - Input channels 0 and 8 can be picked as interrupt sources by the interrupt select.
// - Timers 0 and 1 chain into one 32-bit timer, timer 0 counting a 10 MHz rate.
// - Counter 2 is a 16-bit event counter up to 1 MHz clocked from input channel 15.
// - All three gates are held active so counting never pauses for a gate.
// - Timer 1 output and counter 2 output go to the interrupt logic as sources.
// - Each stage takes divisors 2 to 65535, giving 10 MHz/4 down to 10 MHz/65535^2.
// - Inputs and outputs are each reached as two 8-bit ports.
// - The timer block sits at byte offsets 24..27: counters 0, 1, 2, then control.
module idt_top
  import idt_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic        soft_rst_i,
  input  wire logic [15:0] isolated_input_i,
  input  wire logic [5:0]  hst_addr_i,
  input  wire logic        hst_wr_i,
  input  wire logic        hst_rd_i,
  input  wire logic [7:0]  hst_wdata_i,
  output logic      [7:0]  hst_rdata_o,
  output logic      [15:0] isolated_output_o,
  output logic             int_src0_o,
  output logic             int_src1_o,
  output logic             tmr_out_o,
  output logic             cnt_out_o
);

  logic [15:0]          in_m_q, in_s_q;
  logic [15:0]          dout_q, dout_d;
  logic [7:0]           rdat_q, rdat_d, ictl_q, ictl_d;
  logic                 src0_q, src0_d, src1_q, src1_d;
  logic [IDT_ACC_W-1:0] acc_q, acc_d;
  logic                 osc_tick;
  logic                 o0_prev_q, in15_prev_q;
  logic [2:0]           tick_w, out_w, cwr_w, dwr_w, drd_w;
  logic [7:0]           rd_w [IDT_CNT_N];
  logic [IDT_ACC_W-1:0] acc_sum;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser; only the second stage is ever read
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      in_m_q <= 16'h0000;
      in_s_q <= 16'h0000;
    end else if (ce_i) begin
      in_m_q <= isolated_input_i;
      in_s_q <= in_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fractional 10 MHz tick from the 25 MHz clock; jitter of one clock
  assign acc_sum  = acc_q + IDT_ACC_INC;
  assign osc_tick = ce_i && (acc_sum >= IDT_ACC_MOD);
  always_comb begin
    acc_d = osc_tick ? acc_sum - IDT_ACC_MOD : acc_sum;
  end

  assign tick_w[0] = osc_tick;
  assign tick_w[1] = ce_i && out_w[0] && !o0_prev_q;
  assign tick_w[2] = ce_i && in_s_q[15] && !in15_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < IDT_CNT_N; gi++) begin : g_cnt
      assign cwr_w[gi] = hst_wr_i && hst_addr_i == IDT_A_TCTL
                         && hst_wdata_i[IDT_SC_MSB:IDT_SC_LSB] == 2'(gi);
      assign dwr_w[gi] = hst_wr_i && hst_addr_i == IDT_A_CNT0 + 6'(gi);
      assign drd_w[gi] = hst_rd_i && hst_addr_i == IDT_A_CNT0 + 6'(gi);
      idt_cnt u_cnt (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .tick_i    (tick_w[gi]),
        .ctl_wr_i  (cwr_w[gi]),
        .ctl_i     (hst_wdata_i),
        .data_wr_i (dwr_w[gi]),
        .data_rd_i (drd_w[gi]),
        .wdata_i   (hst_wdata_i),
        .rdata_o   (rd_w[gi]),
        .out_o     (out_w[gi])
      );
    end
  endgenerate

  assign tmr_out_o = out_w[1];
  assign cnt_out_o = out_w[2];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    dout_d = dout_q;
    ictl_d = ictl_q;
    rdat_d = rdat_q;
    if (hst_wr_i) begin
      if (hst_addr_i == IDT_A_DIO_LO) dout_d[7:0]  = hst_wdata_i;
      if (hst_addr_i == IDT_A_DIO_HI) dout_d[15:8] = hst_wdata_i;
      if (hst_addr_i == IDT_A_INTCTL) ictl_d = hst_wdata_i & IDT_IM_MASK;
    end
    if (soft_rst_i) dout_d = IDT_OUT_RST;
    if (hst_rd_i) begin
      unique case (hst_addr_i)
        IDT_A_DIO_LO: rdat_d = in_s_q[7:0];
        IDT_A_DIO_HI: rdat_d = in_s_q[15:8];
        IDT_A_CNT0:   rdat_d = rd_w[0];
        IDT_A_CNT1:   rdat_d = rd_w[1];
        IDT_A_CNT2:   rdat_d = rd_w[2];
        IDT_A_INTCTL: rdat_d = ictl_q;
        default:      rdat_d = 8'h00;
      endcase
    end
    // select sources as levels; edge and flag logic lives downstream
    unique case (ictl_q[IDT_IM0_LSB +: 2])
      IDT_IM_IN:  src0_d = in_s_q[0];
      IDT_IM_IN2: src0_d = in_s_q[0] | in_s_q[4];
      IDT_IM_TC:  src0_d = out_w[1];
      default:    src0_d = 1'b0;
    endcase
    unique case (ictl_q[IDT_IM1_LSB +: 2])
      IDT_IM_IN:  src1_d = in_s_q[8];
      IDT_IM_IN2: src1_d = in_s_q[8] | in_s_q[12];
      IDT_IM_TC:  src1_d = out_w[2];
      default:    src1_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dout_q      <= IDT_OUT_RST;
      ictl_q      <= IDT_INTCTL_RST;
      rdat_q      <= 8'h00;
      src0_q      <= 1'b0;
      src1_q      <= 1'b0;
      acc_q       <= '0;
      o0_prev_q   <= 1'b0;
      in15_prev_q <= 1'b0;
    end else if (ce_i) begin
      dout_q      <= dout_d;
      ictl_q      <= ictl_d;
      rdat_q      <= rdat_d;
      src0_q      <= src0_d;
      src1_q      <= src1_d;
      acc_q       <= acc_d;
      o0_prev_q   <= out_w[0];
      in15_prev_q <= in_s_q[15];
    end
  end

  assign isolated_output_o = dout_q;
  assign hst_rdata_o       = rdat_q;
  assign int_src0_o        = src0_q;
  assign int_src1_o        = src1_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  a_rst_out_low: assert property (@(posedge ref_clk_i) disable iff (1'b0)
    srst_i || (ce_i && soft_rst_i) |=> isolated_output_o == 16'h0000)
    else $error("outputs not low after reset");

  a_out_hold: assert property (
    ce_i && hst_wr_i && hst_addr_i == IDT_A_DIO_HI && !soft_rst_i
      |=> isolated_output_o[15:8] == $past(hst_wdata_i)
          and (!hst_wr_i && !soft_rst_i
               |=> isolated_output_o[15:8] == $past(isolated_output_o[15:8])))
    else $error("output byte not written or not held");

  // enable low must freeze what the host and the field see
  a_ce_freeze: assert property (
    !ce_i |=> isolated_output_o == $past(isolated_output_o) && hst_rdata_o == $past(hst_rdata_o))
    else $error("state moved while clock enable low");

  a_in_sync: assert property (
    $past(ce_i) && $past(ce_i, 2) && !$past(srst_i) && !$past(srst_i, 2)
      |-> in_s_q == $past(isolated_input_i, 2))
    else $error("input synchroniser latency wrong");

  a_in_read: assert property (
    ce_i && hst_rd_i && hst_addr_i == IDT_A_DIO_LO |=> hst_rdata_o == $past(in_s_q[7:0]))
    else $error("input low byte read wrong");

  a_osc_spacing: assert property (
    osc_tick |=> !osc_tick)
    else $error("oscillator tick above 10 MHz");

  a_cnt_clk: assert property (
    ce_i && $rose(in_s_q[15]) && $past(ce_i) |-> tick_w[2])
    else $error("counter 2 missed an input edge");

  a_tmr_chain: assert property (
    ce_i && $rose(out_w[0]) && $past(ce_i) |-> tick_w[1])
    else $error("timer 1 not clocked by timer 0");

  a_src_timer: assert property (
    ce_i && ictl_q[IDT_IM0_LSB +: 2] == IDT_IM_TC |=> int_src0_o == $past(out_w[1]))
    else $error("timer 1 not routed to group 0");

  a_src_input8: assert property (
    ce_i && ictl_q[IDT_IM1_LSB +: 2] == IDT_IM_IN |=> int_src1_o == $past(in_s_q[8]))
    else $error("input 8 not routed to group 1");

  a_src_input0: assert property (
    ce_i && ictl_q[IDT_IM0_LSB +: 2] == IDT_IM_IN |=> int_src0_o == $past(in_s_q[0]))
    else $error("input 0 not routed to group 0");

  a_src_counter: assert property (
    ce_i && ictl_q[IDT_IM1_LSB +: 2] == IDT_IM_TC |=> int_src1_o == $past(out_w[2]))
    else $error("counter 2 not routed to group 1");

  a_cnt_read: assert property (
    ce_i && hst_rd_i && hst_addr_i == IDT_A_CNT2 |=> hst_rdata_o == $past(rd_w[2]))
    else $error("counter 2 data read wrong");

endmodule : idt_top

// >>> rtl/idt_pkg.sv
package idt_pkg;

  localparam int          IDT_CH        = 16;
  localparam int          IDT_CNT_N     = 3;
  localparam int          IDT_CLK_HZ    = 25_000_000;
  localparam int          IDT_OSC_HZ    = 10_000_000;
  localparam int          IDT_ACC_W     = 26;
  localparam logic [25:0] IDT_ACC_MOD   = 26'(IDT_CLK_HZ);
  localparam logic [25:0] IDT_ACC_INC   = 26'(IDT_OSC_HZ);

  // host byte port map
  localparam logic [5:0]  IDT_A_DIO_LO  = 6'h00;
  localparam logic [5:0]  IDT_A_DIO_HI  = 6'h01;
  localparam logic [5:0]  IDT_A_CNT0    = 6'h18;
  localparam logic [5:0]  IDT_A_CNT1    = 6'h19;
  localparam logic [5:0]  IDT_A_CNT2    = 6'h1A;
  localparam logic [5:0]  IDT_A_TCTL    = 6'h1B;
  localparam logic [5:0]  IDT_A_INTCTL  = 6'h20;

  // timer control word fields
  localparam int          IDT_SC_MSB    = 7;
  localparam int          IDT_SC_LSB    = 6;
  localparam int          IDT_RW_MSB    = 5;
  localparam int          IDT_RW_LSB    = 4;
  localparam int          IDT_MD_MSB    = 3;
  localparam int          IDT_MD_LSB    = 1;
  localparam logic [1:0]  IDT_RW_LATCH  = 2'h0;
  localparam logic [1:0]  IDT_RW_LO     = 2'h1;
  localparam logic [1:0]  IDT_RW_HI     = 2'h2;
  localparam logic [1:0]  IDT_RW_BOTH   = 2'h3;

  typedef enum logic [2:0] {
    IDT_M_TERM   = 3'b000,
    IDT_M_HWONE  = 3'b001,
    IDT_M_RATE   = 3'b010,
    IDT_M_SQUARE = 3'b011,
    IDT_M_SWSTB  = 3'b100,
    IDT_M_HWSTB  = 3'b101
  } idt_mode_t;

  // interrupt source select fields
  localparam int          IDT_IM0_LSB   = 0;
  localparam int          IDT_IM1_LSB   = 4;
  localparam logic [1:0]  IDT_IM_OFF    = 2'h0;
  localparam logic [1:0]  IDT_IM_IN     = 2'h1;
  localparam logic [1:0]  IDT_IM_IN2    = 2'h2;
  localparam logic [1:0]  IDT_IM_TC     = 2'h3;
  localparam logic [7:0]  IDT_IM_MASK   = 8'h33;

  localparam logic [15:0] IDT_OUT_RST   = 16'h0000;
  localparam logic [7:0]  IDT_INTCTL_RST = 8'h00;
  localparam logic [15:0] IDT_CNT_ONE   = 16'h0001;
  localparam logic [15:0] IDT_CNT_TWO   = 16'h0002;

endpackage : idt_pkg

// >>> rtl/idt_cnt.sv
`timescale 1ns/1ns
module idt_cnt
  import idt_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic       tick_i,
  input  wire logic       ctl_wr_i,
  input  wire logic [7:0] ctl_i,
  input  wire logic       data_wr_i,
  input  wire logic       data_rd_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  output logic            out_o
);

  logic [15:0] cnt_q, cnt_d, rld_q, rld_d, lat_q, lat_d;
  idt_mode_t   mode_q, mode_d;
  logic [1:0]  rw_q, rw_d;
  logic        wr_hi_q, wr_hi_d, rd_hi_q, rd_hi_d, lat_v_q, lat_v_d;
  logic        pend_q, pend_d, run_q, run_d, out_q, out_d;
  logic [2:0]  md_w;
  logic [15:0] src_w;

  assign md_w  = ctl_i[IDT_MD_MSB:IDT_MD_LSB];
  assign src_w = lat_v_q ? lat_q : cnt_q;
  assign out_o = out_q;
  always_comb begin
    rdata_o = src_w[7:0];
    if (rw_q == IDT_RW_HI || (rw_q == IDT_RW_BOTH && rd_hi_q)) begin
      rdata_o = src_w[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a host write wins over a count tick in the same cycle; ticks are sparse
  always_comb begin
    cnt_d = cnt_q; rld_d = rld_q; lat_d = lat_q; mode_d = mode_q; rw_d = rw_q;
    wr_hi_d = wr_hi_q; rd_hi_d = rd_hi_q; lat_v_d = lat_v_q;
    pend_d = pend_q; run_d = run_q; out_d = out_q;
    if (ctl_wr_i) begin
      if (ctl_i[IDT_RW_MSB:IDT_RW_LSB] == IDT_RW_LATCH) begin
        if (!lat_v_q) begin
          lat_d   = cnt_q;
          lat_v_d = 1'b1;
        end
      end else begin
        rw_d    = ctl_i[IDT_RW_MSB:IDT_RW_LSB];
        mode_d  = md_w[1] ? idt_mode_t'({1'b0, md_w[1:0]}) : idt_mode_t'(md_w);
        wr_hi_d = 1'b0;
        rd_hi_d = 1'b0;
        run_d   = 1'b0;
        pend_d  = 1'b0;
        out_d   = (mode_d != IDT_M_TERM);
      end
    end else if (data_wr_i) begin
      unique case (rw_q)
        IDT_RW_LO: begin
          rld_d[7:0] = wdata_i;
          pend_d     = 1'b1;
        end
        IDT_RW_HI: begin
          rld_d[15:8] = wdata_i;
          pend_d      = 1'b1;
        end
        IDT_RW_BOTH: begin
          wr_hi_d = ~wr_hi_q;
          if (wr_hi_q) begin
            rld_d[15:8] = wdata_i;
            pend_d      = 1'b1;
          end else begin
            rld_d[7:0] = wdata_i;
          end
        end
        default: begin
        end
      endcase
      if (mode_q == IDT_M_TERM) begin
        out_d = 1'b0;
      end
    end else if (tick_i) begin
      // gate is held active, so every tick counts
      if (pend_q) begin
        cnt_d  = rld_q;
        pend_d = 1'b0;
        run_d  = 1'b1;
      end else if (run_q) begin
        unique case (mode_q)
          IDT_M_RATE: begin
            cnt_d = cnt_q - IDT_CNT_ONE;
            if (cnt_q == IDT_CNT_TWO) out_d = 1'b0;
            if (cnt_q == IDT_CNT_ONE) begin
              out_d = 1'b1;
              cnt_d = rld_q;
            end
          end
          IDT_M_SQUARE: begin
            // odd divisors give two equal halves, so the period is the divisor plus one tick
            if (cnt_q <= IDT_CNT_TWO) begin
              out_d = ~out_q;
              cnt_d = rld_q;
            end else begin
              cnt_d = cnt_q - IDT_CNT_TWO;
            end
          end
          default: begin
            cnt_d = cnt_q - IDT_CNT_ONE;
            if (cnt_q == IDT_CNT_ONE && mode_q == IDT_M_TERM) out_d = 1'b1;
          end
        endcase
      end
    end
    if (data_rd_i) begin
      if (rw_q == IDT_RW_BOTH) rd_hi_d = ~rd_hi_q;
      if (rw_q != IDT_RW_BOTH || rd_hi_q) lat_v_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_q <= 16'h0000; rld_q <= 16'h0000; lat_q <= 16'h0000;
      mode_q <= IDT_M_TERM; rw_q <= IDT_RW_BOTH;
      wr_hi_q <= 1'b0; rd_hi_q <= 1'b0; lat_v_q <= 1'b0;
      pend_q <= 1'b0; run_q <= 1'b0; out_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d; rld_q <= rld_d; lat_q <= lat_d;
      mode_q <= mode_d; rw_q <= rw_d;
      wr_hi_q <= wr_hi_d; rd_hi_q <= rd_hi_d; lat_v_q <= lat_v_d;
      pend_q <= pend_d; run_q <= run_d; out_q <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_gate_always_on: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ce_i && tick_i && run_q && !pend_q && !ctl_wr_i && !data_wr_i
      |=> cnt_q != $past(cnt_q) || out_q != $past(out_q))
    else $error("count held while gate should be active");

  a_square_toggle: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ce_i && tick_i && run_q && !pend_q && !ctl_wr_i && !data_wr_i
      && mode_q == IDT_M_SQUARE && cnt_q <= IDT_CNT_TWO
      |=> out_q != $past(out_q) && cnt_q == $past(rld_q))
    else $error("square wave half period not honoured");

endmodule : idt_cnt

// >>> bench/idt_host_model.sv
`timescale 1ns/1ns
module idt_host_model
  import idt_pkg::*;
(
  input  wire logic       ref_clk_i,
  output logic      [5:0] hst_addr_o,
  output logic            hst_wr_o,
  output logic            hst_rd_o,
  output logic      [7:0] hst_wdata_o
);
  initial begin
    hst_addr_o  = 6'h3F;
    hst_wr_o    = 1'b0;
    hst_rd_o    = 1'b0;
    hst_wdata_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one-cycle strobe; address and data scrambled once released
  task automatic wr_b(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    hst_addr_o  <= a;
    hst_wdata_o <= d;
    hst_wr_o    <= 1'b1;
    @(posedge ref_clk_i);
    hst_wr_o    <= 1'b0;
    hst_addr_o  <= ~a;
    hst_wdata_o <= ~d;
  endtask : wr_b

  task automatic rd_b(input logic [5:0] a);
    @(posedge ref_clk_i);
    hst_addr_o <= a;
    hst_rd_o   <= 1'b1;
    @(posedge ref_clk_i);
    hst_rd_o   <= 1'b0;
    hst_addr_o <= ~a;
  endtask : rd_b

  // control word, then lsb, then msb: reload pending only after msb
  task automatic prog(input logic [1:0] ch, input logic [2:0] md, input logic [15:0] dv);
    wr_b(IDT_A_TCTL, {ch, IDT_RW_BOTH, md, 1'b0});
    wr_b(IDT_A_CNT0 + {4'h0, ch}, dv[7:0]);
    wr_b(IDT_A_CNT0 + {4'h0, ch}, dv[15:8]);
  endtask : prog
endmodule : idt_host_model

// >>> bench/tb.sv
`timescale 1ns/1ns
module tb
  import idt_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        srst, ce, soft_rst, rd_pend, int0, int1, tmr_out, cnt_out;
  logic        tmr_prev, int0_prev;
  logic [15:0] iso_in, iso_out;
  logic [5:0]  hst_addr;
  logic        hst_wr, hst_rd;
  logic [7:0]  hst_wdata, hst_rdata;
  logic [31:0] seed;
  logic [7:0]  exp_q[$];
  int          n_errors = 0;
  int          check_count = 0;
  int          edges, iedges;

  always #20 ref_clk = ~ref_clk;

  idt_host_model host_u (
    .ref_clk_i   (ref_clk),
    .hst_addr_o  (hst_addr),
    .hst_wr_o    (hst_wr),
    .hst_rd_o    (hst_rd),
    .hst_wdata_o (hst_wdata)
  );

  idt_top dut_u (
    .ref_clk_i         (ref_clk),
    .srst_i            (srst),
    .ce_i              (ce),
    .soft_rst_i        (soft_rst),
    .isolated_input_i  (iso_in),
    .hst_addr_i        (hst_addr),
    .hst_wr_i          (hst_wr),
    .hst_rd_i          (hst_rd),
    .hst_wdata_i       (hst_wdata),
    .hst_rdata_o       (hst_rdata),
    .isolated_output_o (iso_out),
    .int_src0_o        (int0),
    .int_src1_o        (int1),
    .tmr_out_o         (tmr_out),
    .cnt_out_o         (cnt_out)
  );
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic src_exp(input int m, input logic a, input logic b);
    return (m == 0) ? 1'b0 : (m == 1) ? a : (a | b);
  endfunction : src_exp

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  // read data lands one cycle after the taken read edge
  always @(posedge ref_clk) begin
    if (rd_pend === 1'b1) begin
      chk("hst_rdata_o", 32'(hst_rdata), 32'(exp_q.pop_front()));
    end
    rd_pend <= hst_rd & ce;
  end

  initial begin
    #(40 * 20000);
    n_errors++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst     = 1'b1;
    ce       = 1'b1;
    soft_rst = 1'b0;
    iso_in   = 16'h0000;
    rd_pend  = 1'b0;
    seed     = 32'hC6B7204F;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    chk("isolated_output_o", 32'(iso_out), 32'(IDT_OUT_RST));
    chk("tmr_out_o", 32'(tmr_out), 32'h0);
    // outputs written per byte, inputs read back per byte
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      host_u.wr_b(IDT_A_DIO_LO, seed[7:0]);
      host_u.wr_b(IDT_A_DIO_HI, seed[15:8]);
      @(negedge ref_clk);
      chk("isolated_output_o", 32'(iso_out), 32'(seed[15:0]));
      @(posedge ref_clk);
      iso_in <= seed[31:16] & 16'h7FFF;
      repeat (4) @(posedge ref_clk);
      exp_q.push_back(seed[23:16]);
      exp_q.push_back({1'b0, seed[30:24]});
      host_u.rd_b(IDT_A_DIO_LO);
      host_u.rd_b(IDT_A_DIO_HI);
    end
    // soft reset from a nonzero output pattern
    host_u.wr_b(IDT_A_DIO_LO, 8'hFF);
    @(posedge ref_clk);
    soft_rst <= 1'b1;
    @(posedge ref_clk);
    soft_rst <= 1'b0;
    @(negedge ref_clk);
    chk("isolated_output_o", 32'(iso_out), 32'(IDT_OUT_RST));
    // enable low: the write strobe must be ignored
    @(posedge ref_clk);
    ce <= 1'b0;
    host_u.wr_b(IDT_A_DIO_LO, 8'hA5);
    @(negedge ref_clk);
    chk("isolated_output_o", 32'(iso_out), 32'(IDT_OUT_RST));
    @(posedge ref_clk);
    ce <= 1'b1;
    // hardware reset in mid run from a nonzero pattern
    host_u.wr_b(IDT_A_DIO_HI, 8'hFF);
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    chk("isolated_output_o", 32'(iso_out), 32'(IDT_OUT_RST));
    // source select readback keeps mode bits only; hole reads zero
    host_u.wr_b(IDT_A_INTCTL, 8'hFF);
    exp_q.push_back(IDT_IM_MASK);
    host_u.rd_b(IDT_A_INTCTL);
    exp_q.push_back(8'h00);
    host_u.rd_b(6'h10);
    for (int i = 0; i < 4; i++) begin
      for (int m = 0; m < 3; m++) begin
        seed = xs(seed);
        @(posedge ref_clk);
        iso_in <= seed[15:0] & 16'h7FFF;
        host_u.wr_b(IDT_A_INTCTL, {2'h0, 2'(m), 2'h0, 2'(m)});
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("int_src0_o", 32'(int0), 32'(src_exp(m, seed[0], seed[4])));
        chk("int_src1_o", 32'(int1), 32'(src_exp(m, seed[8], seed[12])));
      end
    end
    // fastest chain: 10 MHz / 4 is one rise every 10 clocks
    host_u.wr_b(IDT_A_INTCTL, 8'h03);
    host_u.prog(2'h0, IDT_M_SQUARE, IDT_CNT_TWO);
    host_u.prog(2'h1, IDT_M_SQUARE, IDT_CNT_TWO);
    repeat (30) @(posedge ref_clk);
    edges     = 0;
    iedges    = 0;
    tmr_prev  = tmr_out;
    int0_prev = int0;
    repeat (1000) begin
      @(negedge ref_clk);
      if (tmr_out === 1'b1 && tmr_prev === 1'b0) edges++;
      if (int0 === 1'b1 && int0_prev === 1'b0) iedges++;
      tmr_prev  = tmr_out;
      int0_prev = int0;
    end
    chk("tmr_out_o rises", 32'(edges >= 98 && edges <= 102), 32'h1);
    chk("int_src0_o rises", 32'(iedges >= 98 && iedges <= 102), 32'h1);
    // event counter, terminal count 5: first tick loads, fifth after that ends
    host_u.wr_b(IDT_A_INTCTL, 8'h30);
    host_u.prog(2'h2, IDT_M_TERM, 16'h0005);
    @(negedge ref_clk);
    chk("cnt_out_o", 32'(cnt_out), 32'h0);
    for (int k = 1; k <= 6; k++) begin
      @(posedge ref_clk);
      iso_in[15] <= 1'b1;
      repeat (15) @(posedge ref_clk);
      iso_in[15] <= 1'b0;
      repeat (15) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("cnt_out_o", 32'(cnt_out), 32'(k == 6));
      if (k == 3) begin
        // latch at count 3, then read lsb and msb of the held value
        host_u.wr_b(IDT_A_TCTL, {2'h2, IDT_RW_LATCH, 4'h0});
        exp_q.push_back(8'h03);
        exp_q.push_back(8'h00);
        host_u.rd_b(IDT_A_CNT2);
        host_u.rd_b(IDT_A_CNT2);
      end
    end
    chk("int_src1_o", 32'(int1), 32'h1);
    repeat (4) @(posedge ref_clk);
    give_verdict();
  end
endmodule : tb
